// ---- rtl/sdpm_pkg.sv ----
// package for the sdram precharge and power-mode command logic
// assumes one clock shared by controller end and device end
package sdpm_pkg;
  localparam int          NBANK         = 4;
  localparam int          ADDR_W        = 13;
  localparam int          AP_BIT        = 10;
  localparam int          BURST_W       = 9;
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          WR_RECOVERY   = 2;
  localparam int          RP_NS         = 15;
  localparam int          RP_CYC        = (RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RAS_NS        = 42;
  localparam int          RAS_CYC       = (RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          XSR_NS        = 75;
  localparam int          XSR_CYC       = (XSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          DAL_CYC       = WR_RECOVERY + RP_CYC;
  localparam logic [3:0]  BANKS_IDLE    = 4'h0;
  localparam logic [7:0]  WAIT_W8       = 8'h00;
  typedef enum logic [3:0] {
    SDPM_NOP, SDPM_ACT, SDPM_PRE, SDPM_PREA, SDPM_WR, SDPM_WRA, SDPM_RD, SDPM_RDA,
    SDPM_REF, SDPM_SELF, SDPM_MRS, SDPM_BST
  } sdpm_cmd_e;
  typedef enum logic [2:0] {SDPM_RUN, SDPM_SUSPEND, SDPM_PDOWN, SDPM_SREF} sdpm_pwr_e;
  typedef logic [ADDR_W-1:0] sdpm_addr_t;
endpackage : sdpm_pkg

// ---- rtl/sdpm_if.sv ----
// command pins between controller and device end
// assumes both ends clocked by the same clk
`timescale 1ns/1ps
interface sdpm_if;
  logic                       cs_n;
  logic                       ras_n;
  logic                       cas_n;
  logic                       we_n;
  logic                       cke;
  logic                       bank_select_low;
  logic                       bank_select_high;
  logic [sdpm_pkg::ADDR_W-1:0] addr;
  modport ctrl (output cs_n, ras_n, cas_n, we_n, cke, bank_select_low, bank_select_high, addr);
  modport dev  (input  cs_n, ras_n, cas_n, we_n, cke, bank_select_low, bank_select_high, addr);
endinterface : sdpm_if

// ---- rtl/sdpm_device.sv ----
// device end: command decode, bank flags, auto-precharge and power states
// assumes pins synchronous to clk_i; burst length and cas latency are static inputs
`timescale 1ns/1ps
module sdpm_device (
  input  wire logic                        clk_i,
  input  wire logic                        nrst_i,
  sdpm_if.dev                              pins,
  input  wire logic [sdpm_pkg::BURST_W-1:0] burst_len_i,
  input  wire logic [1:0]                  cas_latency_i,
  output logic [sdpm_pkg::NBANK-1:0]       bank_active_o,
  output logic [sdpm_pkg::NBANK-1:0]       bank_precharging_o,
  output logic                             burst_busy_o,
  output logic [2:0]                       pwr_state_o,
  output logic                             cmd_error_o
);
  sdpm_pkg::sdpm_pwr_e                 pwr_r;
  logic                                is_wr_burst_r;
  logic                                cke_prev_r;
  logic [sdpm_pkg::NBANK-1:0]          act_r;
  logic [sdpm_pkg::NBANK-1:0]          pre_r;
  logic [sdpm_pkg::BURST_W-1:0]        left_r;
  logic                                ap_r;
  logic                                ap_wr_r;
  logic [1:0]                          ap_bank_r;
  logic [2:0]                          wr_wait_r;
  logic                                err_r;

  wire cmd_cs     = ~pins.cs_n;
  wire [2:0] rcw  = {pins.ras_n, pins.cas_n, pins.we_n};
  wire running    = (pwr_r == sdpm_pkg::SDPM_RUN);
  wire honour     = running & cke_prev_r & cmd_cs;
  wire [1:0] bank = {pins.bank_select_high, pins.bank_select_low};
  wire ap_flag    = pins.addr[sdpm_pkg::AP_BIT];
  wire is_act     = honour & (rcw == 3'b011);
  wire is_pre     = honour & (rcw == 3'b010);
  wire is_wr      = honour & (rcw == 3'b100);
  wire is_rd      = honour & (rcw == 3'b101);
  wire is_bst     = honour & (rcw == 3'b110);
  wire is_self    = honour & (rcw == 3'b001) & ~pins.cke;
  wire busy       = (left_r != '0);
  wire locked     = busy & ap_r;
  wire [sdpm_pkg::NBANK-1:0] bank_dec = sdpm_pkg::NBANK'(1) << bank;
  wire [sdpm_pkg::NBANK-1:0] pre_mask = ap_flag ? '1 : bank_dec;
  // cas latency lead ahead of burst end, burst length plays no part
  wire [sdpm_pkg::BURST_W-1:0] rd_lead = sdpm_pkg::BURST_W'(cas_latency_i);
  // write bursts must not take the read lead, they wait for recovery
  wire rd_ap_fire = ap_r & ~ap_wr_r & ~is_wr_burst_r & busy & (left_r == rd_lead);
  wire wr_ap_fire = ap_wr_r & (wr_wait_r == 3'd1);
  wire ap_fire    = running & (rd_ap_fire | wr_ap_fire);
  wire access_ok  = (is_wr | is_rd) & ~locked;
  wire [sdpm_pkg::BURST_W-1:0] left_nxt = access_ok ? burst_len_i
                                        : (busy ? left_r - 1'b1 : left_r);
  wire cke_low    = ~pins.cke;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) cke_prev_r <= 1'b0;
    else         cke_prev_r <= pins.cke;
  end

  // power state: cke low chooses by bank flags and burst activity
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwr_r <= sdpm_pkg::SDPM_RUN;
    end else begin
      unique case (pwr_r)
        sdpm_pkg::SDPM_RUN: begin
          if (is_self && act_r == sdpm_pkg::BANKS_IDLE) pwr_r <= sdpm_pkg::SDPM_SREF;
          else if (cke_low && (act_r != sdpm_pkg::BANKS_IDLE || busy))
            pwr_r <= sdpm_pkg::SDPM_SUSPEND;
          else if (cke_low) pwr_r <= sdpm_pkg::SDPM_PDOWN;
        end
        sdpm_pkg::SDPM_SUSPEND: if (pins.cke) pwr_r <= sdpm_pkg::SDPM_RUN;
        sdpm_pkg::SDPM_PDOWN:   if (pins.cke) pwr_r <= sdpm_pkg::SDPM_RUN;
        sdpm_pkg::SDPM_SREF:    if (pins.cke) pwr_r <= sdpm_pkg::SDPM_RUN;
      endcase
    end
  end

  // burst and auto-precharge tracking, frozen outside run state
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      left_r    <= '0;
      ap_r      <= 1'b0;
      ap_wr_r   <= 1'b0;
      ap_bank_r <= 2'h0;
      wr_wait_r <= 3'h0;
    end else if (running) begin
      left_r <= left_nxt;
      if (access_ok) begin
        ap_r      <= ap_flag;
        ap_wr_r   <= 1'b0;
        ap_bank_r <= bank;
        wr_wait_r <= 3'h0;
      end else if (ap_r && !ap_wr_r && left_r == 9'd1 && is_wr_burst_r) begin
        ap_wr_r   <= 1'b1;
        wr_wait_r <= 3'(sdpm_pkg::WR_RECOVERY);
      end else if (wr_ap_fire || rd_ap_fire) begin
        ap_r      <= 1'b0;
        ap_wr_r   <= 1'b0;
        wr_wait_r <= 3'h0;
      end else if (wr_wait_r != 3'h0) begin
        wr_wait_r <= wr_wait_r - 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)        is_wr_burst_r <= 1'b0;
    else if (access_ok) is_wr_burst_r <= is_wr;
  end

  // bank flags; precharging flag clears after the precharge time
  logic [2:0] rp_cnt_r;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_r    <= sdpm_pkg::BANKS_IDLE;
      pre_r    <= sdpm_pkg::BANKS_IDLE;
      rp_cnt_r <= 3'h0;
    end else begin
      if (is_act) act_r <= act_r | bank_dec;
      else if (is_pre && !locked) begin
        act_r    <= act_r & ~pre_mask;
        pre_r    <= pre_r | (act_r & pre_mask);
        rp_cnt_r <= 3'(sdpm_pkg::RP_CYC);
      end else if (ap_fire) begin
        act_r    <= act_r & ~(sdpm_pkg::NBANK'(1) << ap_bank_r);
        pre_r    <= pre_r | (sdpm_pkg::NBANK'(1) << ap_bank_r);
        rp_cnt_r <= 3'(sdpm_pkg::RP_CYC);
      end else if (rp_cnt_r != 3'h0) rp_cnt_r <= rp_cnt_r - 3'h1;
      else pre_r <= sdpm_pkg::BANKS_IDLE;
    end
  end

  // flags illegal traffic the controller should never send
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) err_r <= 1'b0;
    else err_r <= (locked & (is_rd | is_wr | is_pre))
               | ((is_rd | is_wr) & ap_flag & (burst_len_i == '1))
               | (is_self & (act_r != sdpm_pkg::BANKS_IDLE))
               | (is_bst & ap_r);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bank_active_o      <= '0;
      bank_precharging_o <= '0;
      burst_busy_o       <= 1'b0;
      pwr_state_o        <= 3'h0;
      cmd_error_o        <= 1'b0;
    end else begin
      bank_active_o      <= act_r;
      bank_precharging_o <= pre_r;
      burst_busy_o       <= busy;
      pwr_state_o        <= 3'(pwr_r);
      cmd_error_o        <= err_r;
    end
  end
endmodule : sdpm_device

// ---- rtl/sdpm_ctrl.sv ----
// controller end: turns one-cycle requests into legal pin commands
// assumes user waits for ready_o before each request
`timescale 1ns/1ps
module sdpm_ctrl (
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  sdpm_if.ctrl                        pins,
  input  wire logic                   req_i,
  input  wire logic [3:0]             cmd_i,
  input  wire logic [1:0]             bank_i,
  input  wire logic [sdpm_pkg::ADDR_W-1:0] addr_i,
  input  wire logic                   sleep_i,
  input  wire logic [sdpm_pkg::BURST_W-1:0] burst_len_i,
  output logic                        ready_o
);
  logic                        cs_n_r, ras_n_r, cas_n_r, we_n_r, cke_r, bsl_r, bsh_r;
  logic [sdpm_pkg::ADDR_W-1:0] addr_r;
  logic [7:0]                  wait_r;
  logic                        lp_r;
  logic [sdpm_pkg::NBANK-1:0]  open_r;

  wire sdpm_pkg::sdpm_cmd_e c = sdpm_pkg::sdpm_cmd_e'(cmd_i);
  wire take      = req_i & ready_o & ~lp_r;
  wire full_page = (burst_len_i == '1);
  // hold-off: auto-precharge accesses cover the low 8 bits of burst length, recovery and precharge; precharge holds rp, activate ras, others one cycle
  wire [7:0] hold = (c == sdpm_pkg::SDPM_WRA || c == sdpm_pkg::SDPM_RDA)
                      ? 8'(burst_len_i) + 8'(sdpm_pkg::DAL_CYC)
                    : (c == sdpm_pkg::SDPM_PRE || c == sdpm_pkg::SDPM_PREA)
                      ? 8'(sdpm_pkg::RP_CYC)
                    : (c == sdpm_pkg::SDPM_ACT) ? 8'(sdpm_pkg::RAS_CYC) : 8'h1;

  assign pins.cs_n             = cs_n_r;
  assign pins.ras_n            = ras_n_r;
  assign pins.cas_n            = cas_n_r;
  assign pins.we_n             = we_n_r;
  assign pins.cke              = cke_r;
  assign pins.bank_select_low  = bsl_r;
  assign pins.bank_select_high = bsh_r;
  assign pins.addr             = addr_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= 4'hf;
      cke_r  <= 1'b1;
      bsl_r  <= 1'b0;
      bsh_r  <= 1'b0;
      addr_r <= '0;
      wait_r <= sdpm_pkg::WAIT_W8;
      lp_r   <= 1'b0;
      open_r <= sdpm_pkg::BANKS_IDLE;
      ready_o <= 1'b1;
    end else begin
      {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= 4'h7;               // nop default
      if (wait_r != 8'h0) wait_r <= wait_r - 8'h1;
      ready_o <= (wait_r <= 8'h1) & ~lp_r & ~take;
      if (lp_r) begin
        cke_r <= ~sleep_i;
        if (!sleep_i) begin
          lp_r   <= 1'b0;                                        // nop follows
          wait_r <= 8'(sdpm_pkg::XSR_CYC);
          ready_o <= 1'b0;
        end
      end else if (sleep_i && wait_r == 8'h0 && ready_o) begin
        cke_r <= 1'b0;
        lp_r  <= 1'b1;
        // open banks forbid self refresh, so cke low with nop gives suspend
        if (open_r == sdpm_pkg::BANKS_IDLE) begin
          {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= 4'h1;            // self refresh
        end
      end else if (take) begin
        bsl_r  <= bank_i[0];
        bsh_r  <= bank_i[1];
        addr_r <= addr_i;
        wait_r <= hold;
        unique case (c)
          sdpm_pkg::SDPM_ACT: begin
            {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= 4'h3;
            open_r <= open_r | (4'h1 << bank_i);
          end
          sdpm_pkg::SDPM_PRE,
          sdpm_pkg::SDPM_PREA: begin
            {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= 4'h2;
            open_r <= (c == sdpm_pkg::SDPM_PREA) ? sdpm_pkg::BANKS_IDLE : (open_r & ~(4'h1 << bank_i));
            addr_r[sdpm_pkg::AP_BIT] <= (c == sdpm_pkg::SDPM_PREA);
          end
          sdpm_pkg::SDPM_WR,
          sdpm_pkg::SDPM_WRA: begin
            {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= 4'h4;
            addr_r[sdpm_pkg::AP_BIT] <= (c == sdpm_pkg::SDPM_WRA) & ~full_page;
          end
          sdpm_pkg::SDPM_RD,
          sdpm_pkg::SDPM_RDA: begin
            {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= 4'h5;
            addr_r[sdpm_pkg::AP_BIT] <= (c == sdpm_pkg::SDPM_RDA) & ~full_page;
          end
          sdpm_pkg::SDPM_REF:  {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= 4'h1;
          sdpm_pkg::SDPM_MRS:  {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= 4'h0;
          sdpm_pkg::SDPM_BST:  {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= 4'h6;
          default:             {cs_n_r, ras_n_r, cas_n_r, we_n_r} <= 4'h7;
        endcase
      end
    end
  end
endmodule : sdpm_ctrl

// ---- tb/sdpm_checker.sv ----
// assertions on the command pins and the device end's state outputs
// assumes the testbench top instantiates it beside the interface
`timescale 1ns/1ps
module sdpm_checker (
  input wire logic                         clk_i,
  input wire logic                         nrst_i,
  input wire logic                         cs_n,
  input wire logic                         ras_n,
  input wire logic                         cas_n,
  input wire logic                         we_n,
  input wire logic                         cke,
  input wire logic                         bank_select_low,
  input wire logic                         bank_select_high,
  input wire logic [sdpm_pkg::ADDR_W-1:0]  addr,
  input wire logic [sdpm_pkg::BURST_W-1:0] burst_len_i,
  input wire logic [sdpm_pkg::NBANK-1:0]   bank_active_o,
  input wire logic [sdpm_pkg::NBANK-1:0]   bank_precharging_o,
  input wire logic                         burst_busy_o,
  input wire logic [2:0]                   pwr_state_o
);
  wire       is_act  = !cs_n && !ras_n && cas_n && we_n;
  wire       is_pre  = !cs_n && !ras_n && cas_n && !we_n;
  wire       is_acc  = !cs_n && ras_n && !cas_n;
  wire       is_sre  = !cs_n && !ras_n && !cas_n && we_n && !cke;
  wire       is_idle = cs_n || (ras_n && cas_n && we_n);
  wire       run_ok  = cke && pwr_state_o == 3'h0;
  wire [1:0] bsel    = {bank_select_high, bank_select_low};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  act_sets_a: assert property (is_act && run_ok && $past(cke) |-> ##[1:2] bank_active_o[bsel])
    else $error("activate did not open its bank");
  pre_one_a: assert property (is_pre && !addr[10] && run_ok && $past(cke) && !burst_busy_o
    |-> ##[1:2] !bank_active_o[bsel]) else $error("single precharge left its bank open");
  pre_all_a: assert property (is_pre && addr[10] && run_ok && $past(cke) && !burst_busy_o
    |-> ##[1:2] bank_active_o == 4'h0) else $error("precharge all left a bank open");
  sre_enter_a: assert property (is_sre && $past(cke) && bank_active_o == 4'h0
    |-> ##[1:2] pwr_state_o == 3'h3) else $error("self refresh not entered");
  sref_idle_a: assert property (pwr_state_o == 3'h3 |-> bank_active_o == 4'h0)
    else $error("self refresh with an open bank");
  sref_hold_a: assert property (pwr_state_o == 3'h3 && !cke && !$past(cke) |=> pwr_state_o == 3'h3)
    else $error("self refresh left while clock enable low");
  fullpage_a: assert property (is_acc && burst_len_i == 9'h1ff |-> !addr[10])
    else $error("auto precharge requested with full page burst");
  nop_exit_a: assert property ($rose(cke) |-> is_idle)
    else $error("no idle command after clock enable rose");
  suspend_a: assert property ($fell(cke) && !is_sre && (bank_active_o != 4'h0 || burst_busy_o)
    |-> ##[1:2] pwr_state_o == 3'h1) else $error("clock suspend not entered");
  cover property (is_act);
  cover property (pwr_state_o == 3'h3);
  cover property ($rose(bank_precharging_o[0]));
endmodule : sdpm_checker

// ---- tb/tb_top.sv ----
// testbench: controller end and device end joined by the pin interface
// assumes one 40 MHz clock; burst length 4 unless a scenario changes it
`timescale 1ns/1ps
module tb_top;
  logic                         clk_i, nrst_i, req_i, sleep_i, ready_o, burst_busy_o, cmd_error_o;
  logic [3:0]                   cmd_i, bank_active_o, bank_precharging_o;
  logic [1:0]                   bank_i, cas_latency_i;
  logic [2:0]                   pwr_state_o;
  logic [sdpm_pkg::ADDR_W-1:0]  addr_i;
  logic [sdpm_pkg::BURST_W-1:0] burst_len_i;
  int                           err_count, checks, cyc, l2, l3, l8, lw;
  sdpm_if pins ();
  sdpm_ctrl sdpm_ctrl_inst (.clk_i(clk_i), .nrst_i(nrst_i), .pins(pins), .req_i(req_i), .cmd_i(cmd_i),
    .bank_i(bank_i), .addr_i(addr_i), .sleep_i(sleep_i), .burst_len_i(burst_len_i), .ready_o(ready_o));
  sdpm_device sdpm_device_inst (.clk_i(clk_i), .nrst_i(nrst_i), .pins(pins), .burst_len_i(burst_len_i),
    .cas_latency_i(cas_latency_i), .bank_active_o(bank_active_o), .bank_precharging_o(bank_precharging_o),
    .burst_busy_o(burst_busy_o), .pwr_state_o(pwr_state_o), .cmd_error_o(cmd_error_o));
  sdpm_checker sdpm_checker_inst (.clk_i(clk_i), .nrst_i(nrst_i), .cs_n(pins.cs_n), .ras_n(pins.ras_n),
    .cas_n(pins.cas_n), .we_n(pins.we_n), .cke(pins.cke), .bank_select_low(pins.bank_select_low),
    .bank_select_high(pins.bank_select_high), .addr(pins.addr), .burst_len_i(burst_len_i),
    .bank_active_o(bank_active_o), .bank_precharging_o(bank_precharging_o), .burst_busy_o(burst_busy_o),
    .pwr_state_o(pwr_state_o));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // hang guard: whole run needs a few hundred cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  task check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task print_verdict();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // ready_o is registered, so it is read at the falling edge only
  task wait_ready();
    int n;
    n = 0;
    while (ready_o !== 1'b1 && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 2000) err_count++;
  endtask : wait_ready
  task issue(input sdpm_pkg::sdpm_cmd_e c, input logic [1:0] b, input logic a10);
    wait_ready();
    req_i = 1'b1;
    cmd_i = c;
    bank_i = b;
    addr_i = '0;
    addr_i[sdpm_pkg::AP_BIT] = a10;
    @(negedge clk_i);
    req_i = 1'b0;
  endtask : issue
  task settle();
    wait_ready();
    repeat (3) @(negedge clk_i);
  endtask : settle
  task t_precharge();
    issue(sdpm_pkg::SDPM_ACT, 2'h1, 1'b0);
    issue(sdpm_pkg::SDPM_ACT, 2'h2, 1'b0);
    settle();
    check("two banks open", bank_active_o, 4'h6);
    issue(sdpm_pkg::SDPM_PRE, 2'h1, 1'b0);
    settle();
    check("single precharge", bank_active_o, 4'h4);
    issue(sdpm_pkg::SDPM_ACT, 2'h0, 1'b0);
    issue(sdpm_pkg::SDPM_PREA, 2'h3, 1'b1);
    settle();
    check("precharge all", bank_active_o, 4'h0);
  endtask : t_precharge
  // lead of precharge start before busy ends; negative once it trails
  task t_ap(input sdpm_pkg::sdpm_cmd_e c, output int lead);
    int fall, rise, hi;
    fall = -1;
    rise = -1;
    hi = 0;
    issue(sdpm_pkg::SDPM_ACT, 2'h0, 1'b0);
    settle();
    issue(c, 2'h0, 1'b1);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_i);
      if (burst_busy_o === 1'b1) hi = 1;
      if (hi == 1 && fall < 0 && burst_busy_o === 1'b0) fall = cyc;
      if (rise < 0 && bank_precharging_o[0] === 1'b1) rise = cyc;
    end
    lead = fall - rise;
    settle();
    check("auto precharge closes", bank_active_o[0], 1'b0);
  endtask : t_ap
  task t_suspend();
    issue(sdpm_pkg::SDPM_ACT, 2'h3, 1'b0);
    settle();
    sleep_i = 1'b1;
    for (int i = 0; i < 20 && pwr_state_o !== 3'h1; i++) @(negedge clk_i);
    check("clock suspend entry", pwr_state_o, 3'h1);
    repeat (5) @(negedge clk_i);
    check("suspend keeps bank", bank_active_o[3], 1'b1);
    sleep_i = 1'b0;
    repeat (3) @(negedge clk_i);
    check("suspend exit", pwr_state_o, 3'h0);
    issue(sdpm_pkg::SDPM_PREA, 2'h0, 1'b1);
    settle();
    check("no command error", cmd_error_o, 1'b0);
  endtask : t_suspend
  task t_sref();
    sleep_i = 1'b1;
    for (int i = 0; i < 60 && pwr_state_o !== 3'h3; i++) @(negedge clk_i);
    check("self refresh entry", pwr_state_o, 3'h3);
    repeat (10) @(negedge clk_i);
    check("self refresh held", pwr_state_o, 3'h3);
    check("clock enable low", pins.cke, 1'b0);
    sleep_i = 1'b0;
    for (int i = 0; i < 60 && pwr_state_o !== 3'h0; i++) @(negedge clk_i);
    check("self refresh exit", pwr_state_o, 3'h0);
    issue(sdpm_pkg::SDPM_ACT, 2'h2, 1'b0);
    settle();
    check("activate after exit", bank_active_o[2], 1'b1);
    issue(sdpm_pkg::SDPM_PREA, 2'h0, 1'b1);
    settle();
  endtask : t_sref
  initial begin
    nrst_i = 1'b0;
    req_i = 1'b0;
    sleep_i = 1'b0;
    cmd_i = 4'h0;
    bank_i = 2'h0;
    addr_i = '0;
    burst_len_i = 9'h004;
    cas_latency_i = 2'h2;
    err_count = 0;
    checks = 0;
    cyc = 0;
    repeat (2) @(negedge clk_i);
    nrst_i = 1'b1;
    t_precharge();
    t_ap(sdpm_pkg::SDPM_WRA, lw);
    check("write recovery", 9'((-lw) >= 1 && (-lw) <= sdpm_pkg::WR_RECOVERY), 9'h001);
    t_ap(sdpm_pkg::SDPM_RDA, l2);
    cas_latency_i = 2'h3;
    t_ap(sdpm_pkg::SDPM_RDA, l3);
    burst_len_i = 9'h008;
    t_ap(sdpm_pkg::SDPM_RDA, l8);
    check("read lead positive", 9'(l2 > 0), 9'h001);
    check("lead follows cas", 9'(l3 - l2), 9'h001);
    check("lead ignores burst", 9'(l8 - l3), 9'h000);
    burst_len_i = 9'h1ff;
    issue(sdpm_pkg::SDPM_ACT, 2'h1, 1'b0);
    settle();
    issue(sdpm_pkg::SDPM_RDA, 2'h1, 1'b1);
    settle();
    check("full page keeps bank", bank_active_o[1], 1'b1);
    issue(sdpm_pkg::SDPM_PREA, 2'h0, 1'b1);
    settle();
    burst_len_i = 9'h004;
    t_suspend();
    t_sref();
    print_verdict();
  end
endmodule : tb_top
